// >>> hw/indicator_pin_mux_config.sv
// Indicator pin multiplexer with configuration and GPIO registers
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module indicator_pin_mux_config #(
  parameter int PINS = indicator_pkg::PIN_COUNT
) (
  // Clock and reset
  input  wire logic            clock_in,
  input  wire logic            rst_in,
  // Straps, sampled while reset is high
  input  wire logic [1:0]      indicator_function_strap_in,
  input  wire logic [PINS-1:0] indicator_enable_strap_in,
  input  wire logic            polarity_strap_in,
  // EEPROM loader override of function and enable; loader_polarity_in is not used
  input  wire logic            loader_write_in,
  input  wire logic [1:0]      loader_function_in,
  input  wire logic [PINS-1:0] loader_enable_in,
  input  wire logic            loader_polarity_in,
  // Register port
  input  wire logic [11:0]     addr_in,
  input  wire logic [31:0]     wdata_in,
  input  wire logic            wr_in,
  input  wire logic            rd_in,
  output logic      [31:0]     rdata_out,
  // Indicator status sources, one per function
  input  wire logic [PINS-1:0] status_func0_in,
  input  wire logic [PINS-1:0] status_func1_in,
  input  wire logic [PINS-1:0] status_func2_in,
  input  wire logic [PINS-1:0] status_func3_in,
  // Pins
  input  wire logic [PINS-1:0] pad_in,
  output logic      [PINS-1:0] pad_out,
  output logic      [PINS-1:0] pad_oe_out,
  output logic      [PINS-1:0] pull_up_en_out,
  output logic      [PINS-1:0] input_en_out
);
  logic [1:0]      function_q, function_d;
  logic [PINS-1:0] enable_q, enable_d;
  logic            active_low_q, active_low_d;
  logic [PINS-1:0] gpio_dir_q, gpio_dir_d;
  logic [PINS-1:0] gpio_buf_q, gpio_buf_d;
  logic [PINS-1:0] gpio_dat_q, gpio_dat_d;
  logic [31:0]     rdata_d;
  logic [PINS-1:0] status_sel;
  logic            push_pull;

  always_comb
  begin
    function_d   = function_q;
    enable_d     = enable_q;
    active_low_d = active_low_q;
    gpio_dir_d   = gpio_dir_q;
    gpio_buf_d   = gpio_buf_q;
    gpio_dat_d   = gpio_dat_q;
    rdata_d      = 32'h0;
    if (rst_in)
    begin
      function_d   = indicator_function_strap_in;
      enable_d     = indicator_enable_strap_in;
      active_low_d = polarity_strap_in;
      gpio_dir_d   = indicator_pkg::GPIO_DIR_RESET;
      gpio_buf_d   = indicator_pkg::GPIO_BUF_RESET;
      gpio_dat_d   = indicator_pkg::GPIO_DAT_RESET;
    end
    else
    begin
      if (loader_write_in)
      begin
        function_d = loader_function_in;
        enable_d   = loader_enable_in;
      end
      if (wr_in && addr_in == indicator_pkg::CFG_ADDR)
      begin
        function_d = wdata_in[indicator_pkg::FUNCTION_LSB +: 2];
        enable_d   = wdata_in[indicator_pkg::ENABLE_LSB +: PINS];
      end
      if (wr_in && addr_in == indicator_pkg::GPIO_CFG_ADDR)
        gpio_buf_d = wdata_in[indicator_pkg::GPIO_BUF_LSB +: PINS];
      if (wr_in && addr_in == indicator_pkg::GPIO_DATA_ADDR)
      begin
        gpio_dir_d = wdata_in[indicator_pkg::GPIO_DIR_LSB +: PINS];
        gpio_dat_d = wdata_in[PINS-1:0];
      end
      if (rd_in)
      begin
        unique case (addr_in)
          indicator_pkg::CFG_ADDR:
          begin
            rdata_d[indicator_pkg::FUNCTION_LSB +: 2] = function_q;
            rdata_d[indicator_pkg::ENABLE_LSB +: PINS] = enable_q;
          end
          indicator_pkg::GPIO_CFG_ADDR:
            rdata_d[indicator_pkg::GPIO_BUF_LSB +: PINS] = gpio_buf_q;
          indicator_pkg::GPIO_DATA_ADDR:
          begin
            rdata_d[indicator_pkg::GPIO_DIR_LSB +: PINS] = gpio_dir_q;
            rdata_d[PINS-1:0] =
              (gpio_dir_q & gpio_dat_q) | (~gpio_dir_q & pad_in);
          end
          default:
            rdata_d = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    function_q   <= function_d;
    enable_q     <= enable_d;
    active_low_q <= active_low_d;
    gpio_dir_q   <= gpio_dir_d;
    gpio_buf_q   <= gpio_buf_d;
    gpio_dat_q   <= gpio_dat_d;
    rdata_out    <= rdata_d;
  end

  always_comb
  begin
    unique case (function_q)
      2'h0: status_sel = status_func0_in;
      2'h1: status_sel = status_func1_in;
      2'h2: status_sel = status_func2_in;
      2'h3: status_sel = status_func3_in;
    endcase
  end

  assign push_pull = (function_q == indicator_pkg::FUNC_PUSH_PULL);

  for (genvar i = 0; i < PINS; i++)
  begin : g_pin
    indicator_pad u_pad (
      .indicator_mode_in (enable_q[i]),
      .push_pull_in      (push_pull),
      .active_low_in     (active_low_q),
      .status_in         (status_sel[i]),
      .gpio_dir_in       (gpio_dir_q[i]),
      .gpio_push_pull_in (gpio_buf_q[i]),
      .gpio_data_in      (gpio_dat_q[i]),
      .pad_out           (pad_out[i]),
      .pad_oe_out        (pad_oe_out[i]),
      .pull_up_en_out    (pull_up_en_out[i]),
      .input_en_out      (input_en_out[i])
    );
  end

  AST_STRAP_LOAD: assert property (@(posedge clock_in)
    $fell(rst_in) |-> enable_q == $past(indicator_enable_strap_in)
      && function_q == $past(indicator_function_strap_in))
    else $error("strap defaults not loaded");
  AST_POLARITY_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
    $past(!rst_in) && loader_write_in |=> $stable(active_low_q))
    else $error("polarity changed by loader");
  AST_LOADER: assert property (@(posedge clock_in) disable iff (rst_in)
    loader_write_in && !wr_in |=> enable_q == $past(loader_enable_in))
    else $error("loader override lost");
  AST_RESERVED: assert property (@(posedge clock_in) disable iff (rst_in)
    rd_in && addr_in == indicator_pkg::CFG_ADDR
      |=> rdata_out[31:10] == 22'h0 && rdata_out[7:6] == 2'h0)
    else $error("reserved bits not zero");
  AST_NO_PULL: assert property (@(posedge clock_in) disable iff (rst_in)
    (enable_q & (pull_up_en_out | input_en_out)) == '0)
    else $error("pull-up on indicator pin");
  AST_PUSH_PULL: assert property (@(posedge clock_in) disable iff (rst_in)
    push_pull |-> (pad_oe_out & enable_q) == enable_q)
    else $error("push-pull not driving");
  AST_ACTIVE_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
    !push_pull && active_low_q
      |-> (enable_q & pad_oe_out & pad_out) == '0)
    else $error("active-low pin driven high");
  AST_GPIO_OD: assert property (@(posedge clock_in) disable iff (rst_in)
    (~enable_q & ~gpio_buf_q & pad_oe_out & pad_out) == '0)
    else $error("open-drain gpio driven high");
  AST_GPIO_IN: assert property (@(posedge clock_in) disable iff (rst_in)
    (~enable_q & ~gpio_dir_q & pad_oe_out) == '0)
    else $error("gpio input driven");

  // Address decode shared by the checks below
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == indicator_pkg::CFG_ADDR)
      || (a == indicator_pkg::GPIO_CFG_ADDR)
      || (a == indicator_pkg::GPIO_DATA_ADDR);
  endfunction

  // Configuration write and its landing one cycle later
  sequence s_cfg_write;
    wr_in && addr_in == indicator_pkg::CFG_ADDR;
  endsequence

  sequence s_cfg_landed;
    ##1 (function_q == $past(wdata_in[indicator_pkg::FUNCTION_LSB +: 2])
      && enable_q == $past(wdata_in[indicator_pkg::ENABLE_LSB +: PINS]));
  endsequence

  // Loader pulse that no register write overrides
  sequence s_loader_pulse;
    loader_write_in && !wr_in;
  endsequence

  AST_CFG_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
    s_cfg_write |-> s_cfg_landed)
    else $error("config write lost");

  AST_LOADER_FUNC: assert property (@(posedge clock_in) disable iff (rst_in)
    s_loader_pulse |=> function_q == $past(loader_function_in))
    else $error("loader function lost");

  AST_UNMAPPED_READ: assert property (@(posedge clock_in) disable iff (rst_in)
    rd_in && !is_mapped(addr_in) |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");

  AST_UNMAPPED_WRITE: assert property (@(posedge clock_in)
    disable iff (rst_in)
    wr_in && !is_mapped(addr_in) && !loader_write_in
      |=> $stable(function_q) && $stable(enable_q))
    else $error("unmapped write changed config");

  AST_READ_IDLE: assert property (@(posedge clock_in) disable iff (rst_in)
    !rd_in |=> rdata_out == 32'h0)
    else $error("read data without read");

  AST_IND_OE: assert property (@(posedge clock_in) disable iff (rst_in)
    !push_pull
      |-> (enable_q & pad_oe_out) == (enable_q & status_sel))
    else $error("indicator enable wrong");

  AST_PP_LEVEL: assert property (@(posedge clock_in) disable iff (rst_in)
    push_pull |-> (enable_q & pad_out) == (enable_q & status_sel))
    else $error("push-pull level wrong");

  AST_OPEN_SOURCE: assert property (@(posedge clock_in) disable iff (rst_in)
    !push_pull && !active_low_q
      |-> (enable_q & pad_oe_out & ~pad_out) == '0)
    else $error("open-source pin driven low");

  AST_POLARITY_LATCH: assert property (@(posedge clock_in)
    rst_in |=> active_low_q == $past(polarity_strap_in))
    else $error("polarity strap not latched");

  AST_GPIO_PP: assert property (@(posedge clock_in) disable iff (rst_in)
    (~enable_q & gpio_dir_q & gpio_buf_q
      & (~pad_oe_out | (pad_out ^ gpio_dat_q))) == '0)
    else $error("push-pull gpio wrong");

  // Open-drain GPIO pulls low on zero
  AST_GPIO_OD_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
    (~enable_q & gpio_dir_q & ~gpio_buf_q
      & (pad_oe_out ^ ~gpio_dat_q)) == '0)
    else $error("open-drain gpio enable wrong");

  // GPIO pins keep pull-up and buffer
  AST_GPIO_PULL: assert property (@(posedge clock_in) disable iff (rst_in)
    (~enable_q & ~(pull_up_en_out & input_en_out)) == '0)
    else $error("gpio pin lost pull-up");
endmodule
`default_nettype wire

// >>> hw/indicator_pkg.sv
// Constants for the indicator pin multiplexer and its configuration register
package indicator_pkg;
  localparam int          PIN_COUNT      = 6;
  localparam logic [11:0] CFG_ADDR       = 12'h1bc;
  localparam logic [11:0] GPIO_CFG_ADDR  = 12'h1e0;
  localparam logic [11:0] GPIO_DATA_ADDR = 12'h1e4;
  localparam int          ENABLE_LSB     = 0;
  localparam int          FUNCTION_LSB   = 8;
  localparam int          GPIO_DIR_LSB   = 16;
  localparam int          GPIO_BUF_LSB   = 0;
  localparam logic [1:0]  FUNC_PUSH_PULL = 2'h3;
  localparam logic [5:0]  GPIO_DIR_RESET = 6'h00;
  localparam logic [5:0]  GPIO_BUF_RESET = 6'h00;
  localparam logic [5:0]  GPIO_DAT_RESET = 6'h00;
endpackage

// >>> hw/indicator_pad.sv
// One shared pin: GPIO or indicator driver selection
`timescale 1ns/1ps
`default_nettype none
module indicator_pad (
  // Selection
  input  wire logic indicator_mode_in,
  input  wire logic push_pull_in,
  input  wire logic active_low_in,
  input  wire logic status_in,
  // GPIO side
  input  wire logic gpio_dir_in,
  input  wire logic gpio_push_pull_in,
  input  wire logic gpio_data_in,
  // Pad side
  output logic      pad_out,
  output logic      pad_oe_out,
  output logic      pull_up_en_out,
  output logic      input_en_out
);
  logic asserted;
  always_comb
  begin
    asserted = status_in;
    pad_out = 1'b0;
    pad_oe_out = 1'b0;
    if (indicator_mode_in)
    begin
      if (push_pull_in)
      begin
        pad_out = asserted;
        pad_oe_out = 1'b1;
      end
      else if (active_low_in)
      begin
        pad_out = 1'b0;
        pad_oe_out = asserted;
      end
      else
      begin
        pad_out = 1'b1;
        pad_oe_out = asserted;
      end
    end
    else if (gpio_dir_in)
    begin
      if (gpio_push_pull_in)
      begin
        pad_out = gpio_data_in;
        pad_oe_out = 1'b1;
      end
      else
      begin
        pad_out = 1'b0;
        pad_oe_out = ~gpio_data_in;
      end
    end
    pull_up_en_out = ~indicator_mode_in;
    input_en_out = ~indicator_mode_in;
  end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the indicator pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock_in;
  logic        rst_in;
  logic        wr;
  logic        rd_s;
  logic        load;
  logic        lpol;
  logic [1:0]  lfunc;
  logic [5:0]  len;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [5:0]  st [4];
  logic [5:0]  pad;
  logic [5:0]  oe;
  logic [5:0]  pull;
  logic [5:0]  inen;
  logic [1:0]  sfunc;
  logic [5:0]  sen;
  logic        spol;
  logic [5:0]  pin;
  int          num_errors;
  int          check_count;

  indicator_pin_mux_config u_indicator_pin_mux_config (
    .clock_in                    (clock_in),
    .rst_in                      (rst_in),
    .indicator_function_strap_in (sfunc),
    .indicator_enable_strap_in   (sen),
    .polarity_strap_in           (spol),
    .loader_write_in             (load),
    .loader_function_in          (lfunc),
    .loader_enable_in            (len),
    .loader_polarity_in          (lpol),
    .addr_in                     (addr),
    .wdata_in                    (wdata),
    .wr_in                       (wr),
    .rd_in                       (rd_s),
    .rdata_out                   (rdata),
    .status_func0_in             (st[0]),
    .status_func1_in             (st[1]),
    .status_func2_in             (st[2]),
    .status_func3_in             (st[3]),
    .pad_in                      (pin),
    .pad_out                     (pad),
    .pad_oe_out                  (oe),
    .pull_up_en_out              (pull),
    .input_en_out                (inen)
  );

  task automatic finish_test();
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clock_in);
    rd_s <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic settle();
    @(posedge clock_in);
    #1;
  endtask

  task automatic t_reset();
    rd_reg(indicator_pkg::CFG_ADDR, 32'h0000012a);
    check(32'(oe), 32'h0a);
    check(32'(pad & oe), 32'h0);
    check(32'(pull), 32'h15);
    check(32'(inen), 32'h15);
  endtask

  task automatic t_funcs();
    wr_reg(indicator_pkg::CFG_ADDR, 32'hffffffff);
    rd_reg(indicator_pkg::CFG_ADDR, 32'h0000033f);
    check(32'(pull | inen), 32'h0);
    for (int f = 0; f < 4; f++)
    begin
      wr_reg(indicator_pkg::CFG_ADDR, 32'h3f | (f << 8));
      settle();
      check(32'(oe), (f == 3) ? 32'h3f : 32'(st[f]));
      check(32'(pad & oe), (f == 3) ? 32'(st[3]) : 32'h0);
    end
  endtask

  task automatic t_loader();
    @(posedge clock_in);
    load <= 1'b1;
    @(posedge clock_in);
    load <= 1'b0;
    rd_reg(indicator_pkg::CFG_ADDR, 32'h0000020f);
    check(32'(oe), 32'h0c);
    check(32'(pad & oe), 32'h0);
    check(32'(pull), 32'h30);
  endtask

  task automatic t_gpio();
    wr_reg(indicator_pkg::CFG_ADDR, 32'h0);
    wr_reg(indicator_pkg::GPIO_DATA_ADDR, 32'h003f0005);
    settle();
    check(32'(oe), 32'h3a);
    check(32'(pad & oe), 32'h0);
    check(32'(pull & inen), 32'h3f);
    wr_reg(indicator_pkg::GPIO_CFG_ADDR, 32'h3f);
    settle();
    check(32'(oe), 32'h3f);
    check(32'(pad), 32'h05);
    rd_reg(indicator_pkg::GPIO_DATA_ADDR, 32'h003f0005);
    rd_reg(12'h100, 32'h0);
    @(posedge clock_in);
    pin <= 6'h2d;
    wr_reg(indicator_pkg::GPIO_DATA_ADDR, 32'h00070005);
    rd_reg(indicator_pkg::GPIO_DATA_ADDR, 32'h0007002d);
  endtask

  task automatic t_open_source();
    @(posedge clock_in);
    rst_in <= 1'b1;
    spol <= 1'b0;
    sfunc <= 2'h2;
    sen <= 6'h3f;
    lpol <= 1'b1;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    rd_reg(indicator_pkg::CFG_ADDR, 32'h0000023f);
    check(32'(oe), 32'h3c);
    check(32'(pad & oe), 32'h3c);
    @(posedge clock_in);
    load <= 1'b1;
    @(posedge clock_in);
    load <= 1'b0;
    rd_reg(indicator_pkg::CFG_ADDR, 32'h0000020f);
    check(32'(oe), 32'h0c);
    check(32'(pad & oe), 32'h0c);
  endtask

  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  initial
  begin
    #200000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    rst_in = 1'b1;
    {wr, rd_s, load} = 3'h0;
    lpol = 1'b0;
    sfunc = 2'h1;
    sen = 6'h2a;
    spol = 1'b1;
    pin = 6'h00;
    lfunc = 2'h2;
    len = 6'h0f;
    addr = 12'h0;
    wdata = 32'h0;
    st[0] = 6'h05;
    st[1] = 6'h0a;
    st[2] = 6'h3c;
    st[3] = 6'h17;
    num_errors = 0;
    check_count = 0;
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    t_reset();
    t_funcs();
    t_loader();
    t_open_source();
    t_gpio();
    finish_test();
  end
endmodule
`default_nettype wire
